// >>> ext_edge_trigger_acq_timing.sv
// external edge trigger acquisition sequencer with apb registers and strobes
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ext_edge_trigger_acq_timing import ext_trig_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_trigger,
    input wire logic xfer_done,
    output logic xfer_req,
    output logic trig_ready,
    output logic single_strobe,
    output logic cont_strobe,
    output logic integrating
);
    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    acq_state_e state_r, state_nxt;
    logic [31:0] ctrl_r, acq_r, integ_r, ss_dly_r, ss_wid_r, cs_per_r, cs_off_r;
    logic [31:0] prdata_r, cnt_r, ev_us_r, cs_pos_r, len;
    logic [6:0] pre_r;
    logic [EDGE_EVENT_CYC-1:0] ev_pipe_r;
    logic trig_q_r, ss_r, cs_r, cs_run_r, load;

    // apb slave, zero wait states
    wire [1:0] variant = ctrl_r[CTRL_VAR_LSB +: 2];
    wire trig_en = ctrl_r[CTRL_EN_BIT];
    wire wr_en = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire addr_hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);
    wire [31:0] status_w = {26'h0, cs_r, ss_r, trig_ready, state_r};
    wire [31:0] rd_mux = (paddr == OFS_CTRL) ? ctrl_r :
                         (paddr == OFS_ACQ) ? acq_r :
                         (paddr == OFS_INTEG) ? integ_r :
                         (paddr == OFS_SS_DLY) ? ss_dly_r :
                         (paddr == OFS_SS_WID) ? ss_wid_r :
                         (paddr == OFS_CS_PER) ? cs_per_r :
                         (paddr == OFS_CS_OFF) ? cs_off_r :
                         (paddr == OFS_STATUS) ? status_w : 32'h0;
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
            acq_r <= 32'h0;
            integ_r <= INTEG_RST;
            ss_dly_r <= 32'h0;
            ss_wid_r <= 32'h0;
            cs_per_r <= 32'h0;
            cs_off_r <= 32'h0;
            prdata_r <= 32'h0;
        end else begin
            if (rd_setup) begin
                prdata_r <= addr_hit ? rd_mux : 32'h0;
            end
            if (wr_en && paddr == OFS_CTRL) ctrl_r <= pwdata;
            if (wr_en && paddr == OFS_ACQ) acq_r <= pwdata;
            if (wr_en && paddr == OFS_INTEG) integ_r <= pwdata;
            if (wr_en && paddr == OFS_SS_DLY) ss_dly_r <= pwdata;
            if (wr_en && paddr == OFS_SS_WID) ss_wid_r <= pwdata;
            if (wr_en && paddr == OFS_CS_PER) cs_per_r <= pwdata;
            if (wr_en && paddr == OFS_CS_OFF) cs_off_r <= pwdata;
        end
    end

    // effective timing values in microseconds, except the third variant's initial busy, which is in clock cycles
    wire [31:0] integ_min = (variant == 2'd1) ? V1_INTEG_MIN_US :
                            (variant == 2'd2) ? V2_INTEG_MIN_US : V0_INTEG_MIN_US;
    wire [31:0] integ_max = (variant == 2'd1) ? V1_INTEG_MAX_US :
                            (variant == 2'd2) ? V2_INTEG_MAX_US : V0_INTEG_MAX_US;
    wire [31:0] integ_eff = clamp(integ_r, integ_min, integ_max);
    wire [31:0] acq_eff = clamp(acq_r, 32'h0, ACQ_MAX_US);
    wire [31:0] v0_busy1 = (integ_eff >= V0_BUSY1_THR_US) ? V0_BUSY1_MIN_US : V0_BUSY1_BASE_US - integ_eff;
    wire [31:0] busy1_len = (variant == 2'd1) ? V1_BUSY1_US :
                            (variant == 2'd2) ? V2_BUSY1_CYC : v0_busy1;
    wire [31:0] busy2_len = (variant == 2'd1) ? V1_BUSY2_US :
                            (variant == 2'd2) ? V2_BUSY2_US : V0_BUSY2_US;

    // 1 us timebase, realigned on every trigger event
    wire tick = (pre_r == 7'(TICK_CYC - 1));
    wire edge_w = ext_trigger && !trig_q_r && trig_en && (state_r == st_idle);
    wire trig_event = ev_pipe_r[EDGE_EVENT_CYC-1];
    wire cnt_zero = (cnt_r == 32'h0);
    // the 15 ns busy of the third variant is counted in clock cycles
    wire step = (state_r == st_busy1 && variant == 2'd2) ? 1'b1 : tick;

    always_comb begin
        state_nxt = state_r;
        load = 1'b0;
        len = 32'h0;
        unique case (state_r)
            st_idle: begin
                if (edge_w) state_nxt = st_edge;
            end
            st_edge: begin
                if (trig_event) begin
                    state_nxt = st_busy1;
                    load = 1'b1;
                    len = busy1_len;
                end
            end
            st_busy1: begin
                if (cnt_zero) begin
                    state_nxt = st_delay;
                    load = 1'b1;
                    len = acq_eff;
                end
            end
            st_delay: begin
                if (cnt_zero) begin
                    state_nxt = st_integ;
                    load = 1'b1;
                    len = integ_eff;
                end
            end
            st_integ: begin
                if (cnt_zero) begin
                    state_nxt = st_busy2;
                    load = 1'b1;
                    len = busy2_len;
                end
            end
            st_busy2: begin
                if (cnt_zero) state_nxt = st_xfer;
            end
            st_xfer: begin
                if (xfer_done) state_nxt = st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= st_idle;
            cnt_r <= 32'h0;
            trig_q_r <= 1'b0;
            ev_pipe_r <= '0;
            pre_r <= 7'h0;
        end else begin
            state_r <= state_nxt;
            trig_q_r <= ext_trigger;
            ev_pipe_r <= {ev_pipe_r[EDGE_EVENT_CYC-2:0], edge_w};
            pre_r <= (trig_event || tick) ? 7'h0 : pre_r + 7'h1;
            if (load) cnt_r <= len;
            else if (step && !cnt_zero) cnt_r <= cnt_r - 32'h1;
        end
    end

    // single strobe, timed from the trigger event
    wire in_win_nxt = (state_nxt == st_busy1) || (state_nxt == st_delay) || (state_nxt == st_integ);
    wire ss_on = (ss_wid_r != 32'h0) && (ev_us_r >= ss_dly_r) && ((ev_us_r - ss_dly_r) < ss_wid_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_us_r <= 32'h0;
            ss_r <= 1'b0;
        end else begin
            // cleared while idle so a count left from the last cycle cannot fire the strobe at the next event
            if (trig_event || state_r == st_idle) ev_us_r <= 32'h0;
            else if (tick && in_win_nxt) ev_us_r <= ev_us_r + 32'h1;
            ss_r <= ss_on && in_win_nxt;
        end
    end

    // continuous strobe: a zero off time means 50 percent duty
    wire per_ok = (cs_per_r != 32'h0) && (cs_per_r < integ_eff);
    wire [31:0] off_eff = (cs_off_r == 32'h0) ? (cs_per_r >> 1) :
                          (cs_off_r > cs_per_r) ? cs_per_r : cs_off_r;
    wire [31:0] cs_high = cs_per_r - off_eff;
    wire period_end = tick && (cs_pos_r == cs_per_r - 32'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_pos_r <= 32'h0;
            cs_run_r <= 1'b0;
            cs_r <= 1'b0;
        end else begin
            if (load && state_nxt == st_integ) begin
                cs_pos_r <= 32'h0;
                cs_run_r <= per_ok;
            end else if (state_r == st_integ && period_end) begin
                cs_pos_r <= 32'h0;
                cs_run_r <= cs_run_r && (cs_per_r <= cnt_r - 32'h1);
            end else if (state_r == st_integ && tick) begin
                cs_pos_r <= cs_pos_r + 32'h1;
            end
            cs_r <= (state_r == st_integ) && cs_run_r && per_ok && (cs_pos_r < cs_high);
        end
    end

    assign single_strobe = ss_r;
    assign cont_strobe = cs_r;
    assign trig_ready = (state_r == st_idle);
    assign xfer_req = (state_r == st_xfer);
    assign integrating = (state_r == st_integ);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_event_delay;
        edge_w |-> ##2 trig_event;
    endproperty
    a_event_delay: assert property (p_event_delay) else $error("event not 2 cycles after edge");

    property p_event_cause;
        trig_event |-> $past(edge_w, 2);
    endproperty
    a_event_cause: assert property (p_event_cause) else $error("event without rising edge");

    property p_ignore_busy;
        (state_r != st_idle) && ext_trigger && !trig_q_r |-> ##2 !trig_event;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) else $error("edge accepted while busy");

    property p_order;
        (state_r == st_integ) && $past(state_r) != st_integ |-> $past(state_r) == st_delay;
    endproperty
    a_order: assert property (p_order) else $error("integration not after delay");

    property p_ss_low;
        (state_r == st_busy2) |-> !single_strobe;
    endproperty
    a_ss_low: assert property (p_ss_low) else $error("single strobe high after integration");

    property p_cs_window;
        (state_r != st_integ) |=> !cont_strobe;
    endproperty
    a_cs_window: assert property (p_cs_window) else $error("continuous strobe outside window");

    property p_cs_period;
        (state_r == st_integ) && !per_ok |=> !cont_strobe;
    endproperty
    a_cs_period: assert property (p_cs_period) else $error("continuous strobe with bad period");

    property p_tick;
        tick |-> ##1 (!tick) [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("timebase tick too frequent");

    property p_xfer;
        $past(state_r) == st_busy2 && state_r != st_busy2 |-> xfer_req && !trig_ready;
    endproperty
    a_xfer: assert property (p_xfer) else $error("no transfer after final busy");

    property p_busy1_v2;
        (state_r == st_edge) && trig_event && variant == 2'd2 && acq_eff == 32'h0 |-> ##5 integrating;
    endproperty
    a_busy1_v2: assert property (p_busy1_v2) else $error("short initial busy wrong");

    property p_ss_delay;
        $rose(single_strobe) |-> ev_us_r >= ss_dly_r;
    endproperty
    a_ss_delay: assert property (p_ss_delay) else $error("single strobe before its delay");

    property p_ss_zero;
        (ss_wid_r == 32'h0) |=> !single_strobe;
    endproperty
    a_ss_zero: assert property (p_ss_zero) else $error("single strobe with zero width");

    property p_cs_start;
        integrating && !$past(integrating) && per_ok && (cs_high != 32'h0) |=> cont_strobe;
    endproperty
    a_cs_start: assert property (p_cs_start) else $error("continuous strobe late at window start");

    property p_cs_full;
        integrating && cs_run_r && (cs_pos_r == 32'h0) |-> cs_per_r <= cnt_r;
    endproperty
    a_cs_full: assert property (p_cs_full) else $error("continuous strobe period cannot finish");

    property p_edge_busy;
        edge_w |=> !trig_ready;
    endproperty
    a_edge_busy: assert property (p_edge_busy) else $error("still ready after accepted edge");

    property p_idle_quiet;
        trig_ready |-> !single_strobe && !cont_strobe && !integrating;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("strobe or window active while idle");

    property p_xfer_hold;
        xfer_req && !xfer_done |=> xfer_req;
    endproperty
    a_xfer_hold: assert property (p_xfer_hold) else $error("transfer dropped before done");

    c_cs: cover property (cont_strobe ##1 !cont_strobe);
    c_ss: cover property (single_strobe ##1 !single_strobe);
    c_cycle: cover property (xfer_req ##1 trig_ready);
    c_v2: cover property (variant == 2'd2 && integrating);
    c_ignored: cover property ((state_r != st_idle) && ext_trigger && !trig_q_r);
endmodule
`default_nettype wire

// >>> ext_trig_pkg.sv
// constants, register map and state type of the external edge trigger sequencer
`default_nettype none
package ext_trig_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int TICK_CYC = US_NS / CLK_PERIOD_NS;
    localparam int TRIG_HIGH_MIN_NS = 10;
    localparam int EDGE_EVENT_MIN_NS = 20;
    localparam int EDGE_EVENT_MAX_NS = 30;
    localparam int EDGE_EVENT_CYC = (EDGE_EVENT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] ACQ_MAX_US = 32'd335500;
    localparam logic [31:0] V0_INTEG_MIN_US = 32'd1;
    localparam logic [31:0] V0_INTEG_MAX_US = 32'd6000000;
    localparam logic [31:0] V0_BUSY1_MIN_US = 32'd1;
    localparam logic [31:0] V0_BUSY1_THR_US = 32'd218;
    localparam logic [31:0] V0_BUSY1_BASE_US = 32'd219;
    localparam logic [31:0] V0_BUSY2_US = 32'd218;
    localparam logic [31:0] V1_INTEG_MIN_US = 32'd3800;
    localparam logic [31:0] V1_INTEG_MAX_US = 32'd10000000;
    localparam logic [31:0] V1_BUSY1_US = 32'd3706;
    localparam logic [31:0] V1_BUSY2_US = 32'd3706;
    localparam logic [31:0] V2_INTEG_MIN_US = 32'd7200;
    localparam logic [31:0] V2_INTEG_MAX_US = 32'd5000000;
    localparam int V2_BUSY1_NS = 15;
    localparam logic [31:0] V2_BUSY1_CYC = 32'((V2_BUSY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] V2_BUSY2_US = 32'd4977;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ACQ = 8'h04;
    localparam logic [7:0] OFS_INTEG = 8'h08;
    localparam logic [7:0] OFS_SS_DLY = 8'h0c;
    localparam logic [7:0] OFS_SS_WID = 8'h10;
    localparam logic [7:0] OFS_CS_PER = 8'h14;
    localparam logic [7:0] OFS_CS_OFF = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam int CTRL_VAR_LSB = 0;
    localparam int CTRL_EN_BIT = 2;
    localparam int ST_READY_BIT = 3;
    localparam int ST_SS_BIT = 4;
    localparam int ST_CS_BIT = 5;
    localparam logic [31:0] CTRL_RST = 32'h00000004;
    localparam logic [31:0] INTEG_RST = 32'h000003e8;
    typedef enum logic [2:0] {
        st_idle, st_edge, st_busy1, st_delay, st_integ, st_busy2, st_xfer
    } acq_state_e;
endpackage
`default_nettype wire

// >>> trig_source.sv
// trigger source model driving the external trigger pin
`timescale 1ns/1ps
`default_nettype none
module trig_source #(
    parameter int HIGH_CYC = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic hold,
    output logic ext_trigger
);
    logic [7:0] cnt_r;

    // each request gives one pulse of HIGH_CYC clocks, 20 ns at the default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
        end else if (go) begin
            cnt_r <= 8'(HIGH_CYC);
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    // hold keeps the pin high as a level with no new edge
    assign ext_trigger = hold | (cnt_r != 8'h00);
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking testbench of the external edge trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module tb import ext_trig_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, hold;
    logic ext_trigger, xfer_done, xfer_req, trig_ready, single_strobe, cont_strobe, integrating;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, s;
    logic [31:0] rst_tab [8];
    logic [32:0] rd_q [$];
    int error_cnt = 0;
    int checks = 0;

    ext_edge_trigger_acq_timing ext_edge_trigger_acq_timing_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_trigger(ext_trigger), .xfer_done(xfer_done), .xfer_req(xfer_req),
        .trig_ready(trig_ready), .single_strobe(single_strobe), .cont_strobe(cont_strobe),
        .integrating(integrating));
    trig_source trig_source_inst (.pclk(pclk), .presetn(presetn), .go(go), .hold(hold), .ext_trigger(ext_trigger));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic near(input string nm, input int seen, input int exp, input int tol);
        check(nm, 33'((seen >= exp - tol && seen <= exp + tol) ? exp : seen), 33'(exp));
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic sig(input int w);
        case (w)
            0: return integrating;
            1: return single_strobe;
            2: return trig_ready;
            3: return xfer_req;
            default: return ext_trigger;
        endcase
    endfunction

    task automatic wait_sig(input int w, input logic v, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sig(w) !== v && n < 40000);
        if (n >= 40000) begin
            error_cnt++;
            give_verdict();
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    // reads are compared when the access phase completes
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0) begin
            check($sformatf("read %h", paddr), {pslverr, prdata}, rd_q.pop_front());
        end
    end

    task automatic fire();
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
    endtask

    // one acquisition on the first variant, times counted from the edge sample
    task automatic run_acq(input int acq, input int integ, input int rises, input bit early);
        int n, t, b1, len, nr, hi, last, first;
        logic pc;
        b1 = (integ >= int'(V0_BUSY1_THR_US)) ? int'(V0_BUSY1_MIN_US) : int'(V0_BUSY1_BASE_US) - integ;
        fire();
        wait_sig(4, 1'b1, n);
        wait_sig(2, 1'b0, t);
        near("ready drop", t, 2, 1);
        if (early) begin
            wait_sig(1, 1'b1, n);
            t += n;
            near("single rise", t, 4, 1);
            wait_sig(1, 1'b0, n);
            t += n;
            near("single width", n, 3 * TICK_CYC, 2);
            fire();
            t += 2;
        end else begin
            repeat (2) @(posedge pclk);
            t += 2;
            check("single held by delay", 33'(single_strobe), 33'h0);
        end
        wait_sig(0, 1'b1, n);
        t += n;
        near("integ start", t, (b1 + acq) * TICK_CYC + 6, 4);
        len = 0;
        nr = 0;
        hi = 0;
        last = 0;
        first = 0;
        pc = 1'b0;
        do begin
            @(posedge pclk);
            len++;
            if (cont_strobe === 1'b1 && pc !== 1'b1) nr++;
            if (cont_strobe === 1'b1) hi++;
            if (single_strobe === 1'b1) last = len;
            if (single_strobe === 1'b1 && first == 0) first = len;
            pc = cont_strobe;
        end while (integrating === 1'b1 && len < 40000);
        near("integ length", len, integ * TICK_CYC + 1, 2);
        check("cont pulses", 33'(nr), 33'(rises));
        // the first run uses a 20 us period, so each pulse is high 10 us
        near("cont high", hi, rises * 10 * TICK_CYC, 4);
        if (!early) near("single forced low", last, len - 1, 2);
        // the late run programs a 200 us single strobe delay
        if (!early) near("single delayed rise", first, (200 - b1 - acq) * TICK_CYC, 4);
        wait_sig(3, 1'b1, n);
        near("final busy", n, int'(V0_BUSY2_US) * TICK_CYC + 1, 3);
        check("cont off", 33'(cont_strobe), 33'h0);
        repeat (5) @(posedge pclk);
        check("ready in transfer", 33'(trig_ready), 33'h0);
        hold <= 1'b1;
        xfer_done <= 1'b1;
        wait_sig(2, 1'b1, n);
        xfer_done <= 1'b0;
        near("ready back", n, 2, 1);
        repeat (10) @(posedge pclk);
        check("level no start", 33'(trig_ready), 33'h1);
        hold <= 1'b0;
    endtask

    initial begin
        int n;
        {presetn, psel, penable, pwrite, go, hold, xfer_done} = 7'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_tab = '{CTRL_RST, 32'h0, INTEG_RST, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8'(i * 4), {1'b0, rst_tab[i]});
        rd(8'h20, {1'b1, 32'h0});
        apb(1'b1, OFS_STATUS, 32'hffffffff);
        rd(OFS_STATUS, 33'h8);
        s = lfsr(32'h19977afd);
        apb(1'b1, OFS_ACQ, s);
        rd(OFS_ACQ, {1'b0, s});
        s = lfsr(s);
        apb(1'b1, OFS_SS_DLY, s);
        rd(OFS_SS_DLY, {1'b0, s});
        apb(1'b1, OFS_INTEG, 32'h0);
        rd(OFS_INTEG, {1'b0, 32'h0});
        apb(1'b1, OFS_ACQ, 32'd5);
        apb(1'b1, OFS_INTEG, 32'd50);
        apb(1'b1, OFS_SS_DLY, 32'd0);
        apb(1'b1, OFS_SS_WID, 32'd3);
        apb(1'b1, OFS_CS_PER, 32'd20);
        apb(1'b1, OFS_CS_OFF, 32'd0);
        run_acq(5, 50, 2, 1'b1);
        apb(1'b1, OFS_ACQ, 32'd0);
        apb(1'b1, OFS_INTEG, 32'd218);
        apb(1'b1, OFS_SS_DLY, 32'd200);
        apb(1'b1, OFS_SS_WID, 32'd1000);
        apb(1'b1, OFS_CS_PER, 32'd218);
        run_acq(0, 218, 0, 1'b0);
        // third variant: clock-cycle initial busy, then an abort by reset inside integration
        apb(1'b1, OFS_CTRL, 32'h00000006);
        fire();
        wait_sig(0, 1'b1, n);
        near("short initial busy", n, int'(V2_BUSY1_CYC) + 6, 1);
        @(posedge pclk);
        check("clamped integration", 33'(cont_strobe), 33'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("reset abort", {30'h0, integrating, cont_strobe, trig_ready}, 33'h1);
        rd(OFS_CTRL, {1'b0, CTRL_RST});
        give_verdict();
    end
endmodule
`default_nettype wire
